//--- rtl/adc_serial_readout_standby.sv
// Digital control of an 18-bit bridge-sensor converter: filtering,
// serial readout on one ready/data line, standby and power-down.
// Assumes all pins are asynchronous to i_clk and the analog modulator
// delivers one bit per sample on i_mod_bit.
//
// What this block does
// - Bridge switch closed converting, open otherwise.
// - Rate pin low 10SPS, high 80SPS.
// - 76.8kHz modulator, fourth-order sinc decimation.
// - Results are 18-bit two's complement.
// - Clip at 1FFFFh and 20000h, never wrap.
// - Line falls on ready; first edge gives MSB.
// - Each later rising edge gives next bit.
// - Nineteenth edge forces line high until ready.
// - After 18 edges last bit holds until update.
// - Unread result overwritten after one conversion.
// - Shift clock held high requests standby.
// - Standby needs 12.5ms or 100ms high.
// - Standby allowed anywhere in a readback.
// - In standby the line stays high.
// - Clock low exits; first result is valid.
// - Slow rate first result near 400.1ms.
// - Power-down pin low resets whole converter.
// - Power-down allowed anywhere in a readback.
`timescale 1ns/100ps
`default_nettype none
module adc_serial_readout_standby
    import adc_readout_pkg::*;
#(
    parameter int unsigned MOD_DIV_P = MOD_DIV_CYC,
    parameter int unsigned DECIM_SLOW_P = DECIM_SLOW,
    parameter int unsigned DECIM_FAST_P = DECIM_FAST,
    parameter int unsigned UPDATE_CYC_P = UPDATE_CYC,
    parameter int unsigned STANDBY_FAST_CYC_P = STANDBY_FAST_CYC,
    parameter int unsigned STANDBY_SLOW_CYC_P = STANDBY_SLOW_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_power_down_n,
    input wire logic i_rate_fast,
    input wire logic i_shift_clk,
    input wire logic i_mod_bit,
    output logic o_ready_data_out,
    output logic o_bridge_switch,
    output logic o_modulator_on
);
    // Pin synchronisers: bit 0 power-down, 1 rate, 2 shift clock, 3 modulator.
    logic [3:0] sync1_ff;
    logic [3:0] sync2_ff;
    logic shift_clk_prev_ff;
    logic rate_prev_ff;

    // Modulator sample divider.
    logic [DIV_W-1:0] div_cnt_ff;
    logic sample_en_ff;

    // Readout sequencer.
    readout_state_t state_ff;
    readout_state_t nxt_state;
    logic [RESULT_W-1:0] data_ff;
    logic [4:0] bit_idx_ff;
    logic [CNT_W-1:0] upd_cnt_ff;
    logic [CNT_W-1:0] high_cnt_ff;
    logic [1:0] drop_cnt_ff;
    logic line_ff;
    logic nxt_line;
    logic bridge_ff;
    logic mod_on_ff;

    // Filter and buffer handshakes.
    logic filt_valid;
    logic [RESULT_W-1:0] filt_result;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [RESULT_W-1:0] fifo_out_data;

    // Two flops before any logic looks at a pin.
    // Reset levels are power-down off and shift clock high, so a clock held high
    // across a release gives no false edge.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sync1_ff <= 4'h5;
            sync2_ff <= 4'h5;
        end else begin
            sync1_ff <= {i_mod_bit, i_shift_clk, i_rate_fast, i_power_down_n};
            sync2_ff <= sync1_ff;
        end
    end

    wire pd_n = sync2_ff[0];
    wire rate_fast = sync2_ff[1];
    wire sclk = sync2_ff[2];
    wire mod_bit = sync2_ff[3];

    // Power-down acts as a synchronous reset of everything behind the pins.
    // A pulse under one clock may be missed; hold it low.
    wire core_rst = i_rst || !pd_n;

    // Edge detection on the synchronised shift clock.
    // Resetting high avoids an edge right after release.
    always_ff @(posedge i_clk) begin
        if (core_rst) begin
            shift_clk_prev_ff <= 1'b1;
            rate_prev_ff <= 1'b0;
        end else begin
            shift_clk_prev_ff <= sclk;
            rate_prev_ff <= rate_fast;
        end
    end

    wire sclk_rise = sclk && !shift_clk_prev_ff;
    wire rate_change = (rate_fast != rate_prev_ff);

    // One-cycle sample enable at the modulator rate.
    // Stopping in standby keeps the modulator quiet.
    wire div_wrap = (div_cnt_ff == DIV_W'(MOD_DIV_P - 1));
    always_ff @(posedge i_clk) begin
        if (core_rst || state_ff == ST_STANDBY) begin
            div_cnt_ff <= '0;
            sample_en_ff <= 1'b0;
        end else begin
            div_cnt_ff <= div_wrap ? '0 : div_cnt_ff + 1'b1;
            sample_en_ff <= div_wrap;
        end
    end

    // Decimation and scaling follow the rate pin.
    // The shifts leave headroom; the clip guards the rest.
    wire [DECIM_W-1:0] decim = rate_fast ? DECIM_W'(DECIM_FAST_P) : DECIM_W'(DECIM_SLOW_P);
    wire [SHIFT_W-1:0] shift = rate_fast ? SHIFT_FAST : SHIFT_SLOW;

    // The filter restarts from empty after standby or a rate change, so
    // its first few results cover only part of the filter window and are dropped.
    wire in_standby = (state_ff == ST_STANDBY);
    wire filt_clear = in_standby || rate_change;
    wire dropping = (drop_cnt_ff != 2'h0);
    wire filt_ready = dropping || fifo_in_ready;
    wire fifo_push = filt_valid && !dropping;

    sinc_decimator u_filter (
        .i_clk(i_clk),
        .i_rst(core_rst),
        .i_clear(filt_clear),
        .i_sample_en(sample_en_ff),
        .i_bit(mod_bit),
        .i_decim(decim),
        .i_shift(shift),
        .o_valid(filt_valid),
        .i_ready(filt_ready),
        .o_result(filt_result)
    );

    // Count discarded results after reset, standby exit or rate change.
    always_ff @(posedge i_clk) begin
        if (core_rst || filt_clear) drop_cnt_ff <= SETTLE_DROP;
        else if (filt_valid && dropping) drop_cnt_ff <= drop_cnt_ff - 1'b1;
    end

    // The sequencer drains the buffer except while it is loading a word or in standby.
    // Results are far apart, so one word rarely waits.
    wire seq_take = fifo_out_valid && (state_ff != ST_UPDATE) && !in_standby;

    result_fifo #(
        .WIDTH(RESULT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rst(core_rst),
        .i_flush(in_standby),
        .i_in_valid(fifo_push),
        .o_in_ready(fifo_in_ready),
        .i_in_data(filt_result),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(seq_take),
        .o_out_data(fifo_out_data)
    );

    // Standby is timed only once the ready line has fallen.
    wire after_ready = (state_ff == ST_READY) || (state_ff == ST_SHIFT) ||
        (state_ff == ST_HOLD) || (state_ff == ST_HIGH);
    wire [CNT_W-1:0] standby_lim = rate_fast ? CNT_W'(STANDBY_FAST_CYC_P - 1) :
        CNT_W'(STANDBY_SLOW_CYC_P - 1);
    // Once armed, the count survives a new update: at the slow
    // rate the activation time outlasts a conversion.
    wire hi_armed = after_ready || (high_cnt_ff != '0);
    wire standby_hit = hi_armed && sclk && (high_cnt_ff == standby_lim);
    wire upd_done = (upd_cnt_ff == CNT_W'(UPDATE_CYC_P - 1));

    // High-time counter restarts whenever the clock drops.
    // It stops at the limit so standby holds with the clock.
    always_ff @(posedge i_clk) begin
        if (core_rst || !sclk || !hi_armed) high_cnt_ff <= '0;
        else if (!standby_hit) high_cnt_ff <= high_cnt_ff + 1'b1;
    end

    // Next state and next line level.
    // Standby outranks a new result so no request is lost;
    // a word taken in that cycle is loaded into data_ff but never shifted out.
    always_comb begin
        nxt_state = state_ff;
        nxt_line = line_ff;
        if (standby_hit) begin
            nxt_state = ST_STANDBY;
            nxt_line = 1'b1;
        end else if (in_standby) begin
            nxt_line = 1'b1;
            if (!sclk) nxt_state = ST_WAIT;
        end else if (seq_take) begin
            nxt_state = ST_UPDATE;
            nxt_line = 1'b1;
        end else begin
            case (state_ff)
                ST_WAIT: begin
                    nxt_line = 1'b1;
                end
                ST_UPDATE: begin
                    if (upd_done) begin
                        nxt_state = ST_READY;
                        nxt_line = 1'b0;
                    end
                end
                ST_READY: begin
                    if (sclk_rise) begin
                        nxt_state = ST_SHIFT;
                        nxt_line = data_ff[MSB_INDEX];
                    end
                end
                ST_SHIFT: begin
                    if (sclk_rise) begin
                        nxt_line = data_ff[bit_idx_ff];
                        if (bit_idx_ff == 5'h00) nxt_state = ST_HOLD;
                    end
                end
                ST_HOLD: begin
                    if (sclk_rise) begin
                        nxt_state = ST_HIGH;
                        nxt_line = 1'b1;
                    end
                end
                ST_HIGH: begin
                    nxt_line = 1'b1;
                end
                default: begin
                    nxt_state = ST_WAIT;
                    nxt_line = 1'b1;
                end
            endcase
        end
    end

    // Sequencer state and line register.
    always_ff @(posedge i_clk) begin
        if (core_rst) begin
            state_ff <= ST_WAIT;
            line_ff <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            line_ff <= nxt_line;
        end
    end

    // Result capture and bit index.
    // The index wraps in the hold state, which never reads it.
    always_ff @(posedge i_clk) begin
        if (core_rst) begin
            data_ff <= CODE_ZERO;
            bit_idx_ff <= MSB_INDEX;
        end else if (seq_take) begin
            data_ff <= fifo_out_data;
            bit_idx_ff <= MSB_INDEX;
        end else if (sclk_rise && (state_ff == ST_READY || state_ff == ST_SHIFT)) begin
            bit_idx_ff <= bit_idx_ff - 1'b1;
        end
    end

    // The line stays high for the whole update interval before falling.
    // The count parks at its end value until the state moves.
    always_ff @(posedge i_clk) begin
        if (core_rst || state_ff != ST_UPDATE) upd_cnt_ff <= '0;
        else if (!upd_done) upd_cnt_ff <= upd_cnt_ff + 1'b1;
    end

    // Switch and modulator power follow the conversion state.
    // Both follow the next state, in step with the line.
    always_ff @(posedge i_clk) begin
        if (core_rst) begin
            bridge_ff <= 1'b0;
            mod_on_ff <= 1'b0;
        end else begin
            bridge_ff <= (nxt_state != ST_STANDBY);
            mod_on_ff <= (nxt_state != ST_STANDBY);
        end
    end

    assign o_ready_data_out = line_ff;
    assign o_bridge_switch = bridge_ff;
    assign o_modulator_on = mod_on_ff;
endmodule : adc_serial_readout_standby
`default_nettype wire

//--- rtl/adc_readout_pkg.sv
// Constants shared by the bridge-sensor converter control logic.
// Assumes a single 100 MHz system clock drives every block that imports it.
package adc_readout_pkg;

    // System clock and modulator sampling rate.
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned MOD_RATE_HZ = 76_800;
    localparam int unsigned DIV_W = 11;
    localparam int unsigned MOD_DIV_CYC = CLK_HZ / MOD_RATE_HZ;

    // Output data rates and the matching decimation ratios.
    localparam int unsigned RATE_SLOW_SPS = 10;
    localparam int unsigned RATE_FAST_SPS = 80;
    localparam int unsigned DECIM_W = 13;
    localparam int unsigned DECIM_SLOW = MOD_RATE_HZ / RATE_SLOW_SPS;
    localparam int unsigned DECIM_FAST = MOD_RATE_HZ / RATE_FAST_SPS;

    // Filter order, accumulator width and scaling shifts per rate.
    localparam int unsigned FILT_ORDER = 4;
    localparam int unsigned ACC_W = 56;
    localparam int unsigned SHIFT_W = 6;
    localparam logic [SHIFT_W-1:0] SHIFT_SLOW = 6'h23;
    localparam logic [SHIFT_W-1:0] SHIFT_FAST = 6'h17;

    // Result word format.
    localparam int unsigned RESULT_W = 18;
    localparam logic [RESULT_W-1:0] CODE_ZERO = 18'h00000;
    localparam logic [RESULT_W-1:0] CODE_POS_FS = 18'h1FFFF;
    localparam logic [RESULT_W-1:0] CODE_NEG_FS = 18'h20000;
    localparam logic [4:0] MSB_INDEX = 5'h11;

    // Result update interval.
    localparam int unsigned RESULT_UPDATE_INTERVAL_US = 90;
    localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
    localparam int unsigned UPDATE_CYC = RESULT_UPDATE_INTERVAL_US * CYC_PER_US;

    // Least standby activation time, per rate.
    localparam int unsigned STANDBY_FAST_US = 12_500;
    localparam int unsigned STANDBY_SLOW_US = 100_000;
    localparam int unsigned STANDBY_FAST_CYC = STANDBY_FAST_US * CYC_PER_US;
    localparam int unsigned STANDBY_SLOW_CYC = STANDBY_SLOW_US * CYC_PER_US;
    localparam int unsigned CNT_W = 24;

    // Results dropped after a filter restart; the next one is settled.
    localparam logic [1:0] SETTLE_DROP = 2'h3;

    // Result buffer depth.
    localparam int unsigned FIFO_DEPTH = 8;

    // Readout sequencer states.
    typedef enum logic [2:0] {
        ST_WAIT = 3'b000,
        ST_UPDATE = 3'b001,
        ST_READY = 3'b010,
        ST_SHIFT = 3'b011,
        ST_HOLD = 3'b100,
        ST_HIGH = 3'b101,
        ST_STANDBY = 3'b110
    } readout_state_t;

endpackage : adc_readout_pkg

//--- rtl/result_fifo.sv
// Small synchronous FIFO holding finished conversion results.
// Assumes both sides run on i_clk; i_flush empties it in one cycle.
`timescale 1ns/100ps
`default_nettype none
module result_fifo #(
    parameter int unsigned WIDTH = 18,
    parameter int unsigned DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_flush,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;

    // Pointers carry one extra bit so full and empty differ honestly.
    wire empty = (wr_ptr_ff == rd_ptr_ff);
    wire full = (wr_ptr_ff == {~rd_ptr_ff[AW], rd_ptr_ff[AW-1:0]});
    wire do_push = i_in_valid && !full;
    wire do_pop = i_out_ready && !empty;

    assign o_in_ready = !full;
    assign o_out_valid = !empty;
    assign o_out_data = mem_ff[rd_ptr_ff[AW-1:0]];

    // Storage is written only on an accepted push.
    always_ff @(posedge i_clk) begin
        if (do_push) begin
            mem_ff[wr_ptr_ff[AW-1:0]] <= i_in_data;
        end
    end

    // Pointer update; a flush discards everything held.
    always_ff @(posedge i_clk) begin
        if (i_rst || i_flush) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end else begin
            if (do_push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
            if (do_pop) rd_ptr_ff <= rd_ptr_ff + 1'b1;
        end
    end
endmodule : result_fifo
`default_nettype wire

//--- rtl/sinc_decimator.sv
// Fourth-order sinc decimation filter for a one-bit modulator stream.
// Assumes i_sample_en pulses once per modulator sample on i_clk.
`timescale 1ns/100ps
`default_nettype none
module sinc_decimator
    import adc_readout_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_clear,
    input wire logic i_sample_en,
    input wire logic i_bit,
    input wire logic [DECIM_W-1:0] i_decim,
    input wire logic [SHIFT_W-1:0] i_shift,
    output logic o_valid,
    input wire logic i_ready,
    output logic [RESULT_W-1:0] o_result
);
    logic [ACC_W-1:0] integ_ff [FILT_ORDER];
    logic [ACC_W-1:0] dly_ff [FILT_ORDER];
    logic [ACC_W-1:0] comb_in [FILT_ORDER+1];
    logic [ACC_W-1:0] integ_in [FILT_ORDER];
    logic [DECIM_W-1:0] dec_cnt_ff;
    logic [RESULT_W-1:0] result_ff;
    logic valid_ff;

    // The modulator bit stands for +1 or -1 full scale.
    wire [ACC_W-1:0] sample = i_bit ? {{(ACC_W-1){1'b0}}, 1'b1} : {ACC_W{1'b1}};
    wire dec_tick = i_sample_en && (dec_cnt_ff == i_decim - 1'b1);

    // Integrators and combs wrap modulo the width, which the comb cancels.
    genvar k;
    generate
        for (k = 0; k < FILT_ORDER; k++) begin : g_stage
            if (k == 0) begin : g_head
                assign integ_in[k] = sample;
            end else begin : g_tail
                assign integ_in[k] = integ_ff[k-1];
            end
            assign comb_in[k+1] = comb_in[k] - dly_ff[k];
            always_ff @(posedge i_clk) begin
                if (i_rst || i_clear) begin
                    integ_ff[k] <= '0;
                    dly_ff[k] <= '0;
                end else begin
                    if (i_sample_en) integ_ff[k] <= integ_ff[k] + integ_in[k];
                    if (dec_tick) dly_ff[k] <= comb_in[k];
                end
            end
        end
    endgenerate
    assign comb_in[0] = integ_ff[FILT_ORDER-1];

    // Scale to the result width and clip rather than wrap at full scale.
    wire signed [ACC_W-1:0] scaled = $signed(comb_in[FILT_ORDER]) >>> i_shift;
    wire signed [ACC_W-1:0] pos_lim = ACC_W'($signed(CODE_POS_FS));
    wire signed [ACC_W-1:0] neg_lim = -pos_lim - 1'sb1;
    wire [RESULT_W-1:0] clipped = (scaled > pos_lim) ? CODE_POS_FS :
        (scaled < neg_lim) ? CODE_NEG_FS : scaled[RESULT_W-1:0];

    // Decimation counter.
    always_ff @(posedge i_clk) begin
        if (i_rst || i_clear) dec_cnt_ff <= '0;
        else if (dec_tick) dec_cnt_ff <= '0;
        else if (i_sample_en) dec_cnt_ff <= dec_cnt_ff + 1'b1;
    end

    // A result waits for the consumer; a newer one replaces it.
    always_ff @(posedge i_clk) begin
        if (i_rst || i_clear) begin
            valid_ff <= 1'b0;
            result_ff <= CODE_ZERO;
        end else if (dec_tick) begin
            valid_ff <= 1'b1;
            result_ff <= clipped;
        end else if (i_ready) begin
            valid_ff <= 1'b0;
        end
    end

    assign o_valid = valid_ff;
    assign o_result = result_ff;
endmodule : sinc_decimator
`default_nettype wire

//--- verif/adc_readout_sva.sv
// Checker for the converter control block: switch, standby and line levels.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module adc_readout_sva #(
    parameter int unsigned SB_FAST = 50,
    parameter int unsigned SB_SLOW = 100
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_power_down_n,
    input wire logic i_rate_fast,
    input wire logic i_shift_clk,
    input wire logic i_mod_bit,
    input wire logic o_ready_data_out,
    input wire logic o_bridge_switch,
    input wire logic o_modulator_on
);
    logic [23:0] hi_cnt_ff;
    logic [3:0] pd_cnt_ff;
    logic [3:0] run_cnt_ff;
    logic [23:0] nxt_hi_cnt;
    logic [3:0] nxt_pd_cnt;
    logic [3:0] nxt_run_cnt;
    logic settled;
    // Saturating counts of shift clock high time, power pin high time and run time.
    assign nxt_hi_cnt = !i_shift_clk ? 24'h000000 : hi_cnt_ff + {23'h0, ~&hi_cnt_ff};
    assign nxt_pd_cnt = !i_power_down_n ? 4'h0 : pd_cnt_ff + {3'h0, ~&pd_cnt_ff};
    assign nxt_run_cnt = run_cnt_ff + {3'h0, ~&run_cnt_ff};
    // Settled means no reset or power-down edge can still be working through.
    assign settled = (pd_cnt_ff > 4'h8) && (run_cnt_ff > 4'h8);
    // Cleared by reset only so the counts never start unknown.
    always_ff @(posedge i_clk) begin
        hi_cnt_ff <= i_rst ? 24'h000000 : nxt_hi_cnt;
        pd_cnt_ff <= i_rst ? 4'h0 : nxt_pd_cnt;
        run_cnt_ff <= i_rst ? 4'h0 : nxt_run_cnt;
    end
    sequence s_pd_held;
        !i_power_down_n [*4];
    endsequence
    sequence s_clk_low_run;
        !i_shift_clk [*8];
    endsequence
    a_reset_line_high:
        assert property (@(posedge i_clk) i_rst |=> o_ready_data_out)
        else $error("line low after reset");
    a_reset_switch_open:
        assert property (@(posedge i_clk) i_rst |=> !o_bridge_switch && !o_modulator_on)
        else $error("switch closed after reset");
    a_pdown_all_off:
        assert property (@(posedge i_clk) disable iff (i_rst)
            s_pd_held |=> !o_bridge_switch && o_ready_data_out)
        else $error("power-down not honoured");
    a_mod_with_switch:
        assert property (@(posedge i_clk) disable iff (i_rst) o_modulator_on == o_bridge_switch)
        else $error("modulator and switch disagree");
    a_open_line_high:
        assert property (@(posedge i_clk) disable iff (i_rst) !o_bridge_switch |-> o_ready_data_out)
        else $error("line low while switch open");
    a_standby_min_time:
        assert property (@(posedge i_clk) disable iff (i_rst) $fell(o_bridge_switch) && settled
            |-> hi_cnt_ff >= (i_rate_fast ? SB_FAST : SB_SLOW))
        else $error("standby entered too early");
    a_wake_closes:
        assert property (@(posedge i_clk) disable iff (i_rst)
            $fell(i_shift_clk) && !o_bridge_switch && settled |-> ##[1:6] o_bridge_switch)
        else $error("standby exit too slow");
    a_run_switch_closed:
        assert property (@(posedge i_clk) disable iff (i_rst)
            s_clk_low_run ##0 settled |-> o_bridge_switch)
        else $error("switch open while converting");
endmodule : adc_readout_sva
bind adc_serial_readout_standby adc_readout_sva #(
    .SB_FAST(STANDBY_FAST_CYC_P),
    .SB_SLOW(STANDBY_SLOW_CYC_P)
) u_sva (.i_clk(i_clk), .i_rst(i_rst), .i_power_down_n(i_power_down_n),
    .i_rate_fast(i_rate_fast), .i_shift_clk(i_shift_clk), .i_mod_bit(i_mod_bit),
    .o_ready_data_out(o_ready_data_out), .o_bridge_switch(o_bridge_switch),
    .o_modulator_on(o_modulator_on));
`default_nettype wire

//--- verif/adc_host_model.sv
// Host model: polls the ready/data line and clocks result bits out.
// Assumes i_clk is the system clock; one shift bit takes 80 ns.
`timescale 1ns/100ps
`default_nettype none
module adc_host_model (
    input wire logic i_clk,
    input wire logic i_ready_data_out,
    output logic o_shift_clk
);
    // The shift clock stands low between frames; high means a standby request.
    initial begin
        o_shift_clk = 1'b0;
    end
    // Every change lands one step after a system clock edge, never on it.
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick
    // Raising soon after ready fell keeps well inside the request window.
    task automatic set_clk(input logic v);
        o_shift_clk = v;
    endtask : set_clk
    // Waits out the update (line high) and then the fall of a fresh result.
    task automatic wait_ready(output logic ok);
        int k;
        k = 0;
        while (i_ready_data_out !== 1'b1 && k < 6000) begin
            tick(1);
            k++;
        end
        while (i_ready_data_out !== 1'b0 && k < 6000) begin
            tick(1);
            k++;
        end
        ok = k < 6000;
    endtask : wait_ready
    // Bits are taken late in the low phase, long after the line has moved.
    task automatic read_word(input int n, input logic fresh, output logic [17:0] d,
                             output logic tail, output logic ok);
        ok = 1'b1;
        d = 18'h00000;
        if (fresh) begin
            wait_ready(ok);
        end
        for (int i = 0; i < n; i++) begin
            o_shift_clk = 1'b1;
            tick(4);
            o_shift_clk = 1'b0;
            tick(4);
            if (i < 18) begin
                d = {d[16:0], i_ready_data_out};
            end
        end
        tail = i_ready_data_out;
    endtask : read_word
endmodule : adc_host_model
`default_nettype wire

//--- verif/adc_serial_readout_standby_test.sv
// Self-checking bench for the converter control block with a host model.
// Assumes the checker is bound in and counts are shortened for simulation.
`timescale 1ns/100ps
`default_nettype none
module adc_serial_readout_standby_test;
    typedef struct {logic rate; logic bitv; logic [17:0] code;} row_t;
    logic i_clk;
    logic i_rst;
    logic i_power_down_n;
    logic i_rate_fast;
    logic i_mod_bit;
    logic shift_clk;
    logic o_ready_data_out;
    logic o_bridge_switch;
    logic o_modulator_on;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0;
    int t0;
    row_t rows [4];
    logic [17:0] d;
    logic t;
    logic ok;
    adc_serial_readout_standby #(.MOD_DIV_P(4), .DECIM_SLOW_P(128), .DECIM_FAST_P(64),
        .UPDATE_CYC_P(10), .STANDBY_FAST_CYC_P(50), .STANDBY_SLOW_CYC_P(100)
    ) u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_power_down_n(i_power_down_n),
        .i_rate_fast(i_rate_fast), .i_shift_clk(shift_clk), .i_mod_bit(i_mod_bit),
        .o_ready_data_out(o_ready_data_out), .o_bridge_switch(o_bridge_switch),
        .o_modulator_on(o_modulator_on));
    adc_host_model u_host (.i_clk(i_clk), .i_ready_data_out(o_ready_data_out),
        .o_shift_clk(shift_clk));
    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up
    initial begin
        i_clk = 1'b0;
        forever begin
            #5 i_clk = ~i_clk;
        end
    end
    // A hang costs at most the ceiling; the full run needs about two fifths of it.
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            err_count++;
            wrap_up();
        end
    end
    // Codes follow from a full-scale one-bit stream scaled down by the rate's shift.
    initial begin
        i_rst = 1'b1;
        i_power_down_n = 1'b1;
        i_rate_fast = 1'b0;
        i_mod_bit = 1'b1;
        rows[0] = '{1'b0, 1'b1, 18'h00000};
        rows[1] = '{1'b0, 1'b0, 18'h3FFFF};
        rows[2] = '{1'b1, 1'b1, 18'h00002};
        rows[3] = '{1'b1, 1'b0, 18'h3FFFE};
        u_host.tick(15);
        check({16'h0, o_bridge_switch, o_ready_data_out}, 18'h00001);
        u_host.tick(1);
        i_rst = 1'b0;
        foreach (rows[r]) begin
            i_rate_fast = rows[r].rate;
            i_mod_bit = rows[r].bitv;
            repeat (6) u_host.read_word(19, 1'b1, d, t, ok);
            check(d, rows[r].code);
            check({16'h0, ok, t}, 18'h00003);
            $display("row %0d done", r);
        end
        u_host.read_word(18, 1'b1, d, t, ok);
        check(d, 18'h3FFFE);
        u_host.tick(20);
        check({17'h0, o_ready_data_out}, {17'h0, d[0]});
        $display("eighteen edge read done");
        u_host.read_word(5, 1'b1, d, t, ok);
        i_power_down_n = 1'b0;
        u_host.tick(6);
        check({15'h0, o_bridge_switch, o_modulator_on, o_ready_data_out}, 18'h00001);
        i_power_down_n = 1'b1;
        u_host.tick(200);
        check({17'h0, o_ready_data_out}, 18'h00001);
        u_host.read_word(19, 1'b1, d, t, ok);
        check(d, 18'h3FFFE);
        $display("power-down done");
        i_rate_fast = 1'b0;
        repeat (5) u_host.read_word(19, 1'b1, d, t, ok);
        u_host.read_word(3, 1'b1, d, t, ok);
        u_host.set_clk(1'b1);
        u_host.tick(60);
        check({17'h0, o_bridge_switch}, 18'h00001);
        u_host.tick(60);
        check({16'h0, o_bridge_switch, o_ready_data_out}, 18'h00001);
        u_host.set_clk(1'b0);
        t0 = cyc;
        u_host.tick(8);
        check({17'h0, o_bridge_switch}, 18'h00001);
        u_host.wait_ready(ok);
        check({17'h0, (cyc - t0 > 1536) && (cyc - t0 < 2560)}, 18'h00001);
        u_host.read_word(19, 1'b0, d, t, ok);
        check(d, 18'h3FFFF);
        $display("standby done");
        t0 = cyc;
        u_host.wait_ready(ok);
        u_host.wait_ready(ok);
        check({17'h0, ok && (cyc - t0 < 1100)}, 18'h00001);
        u_host.read_word(4, 1'b1, d, t, ok);
        i_rst = 1'b1;
        u_host.tick(16);
        check({16'h0, o_bridge_switch, o_ready_data_out}, 18'h00001);
        i_rst = 1'b0;
        u_host.tick(100);
        check({17'h0, o_ready_data_out}, 18'h00001);
        u_host.read_word(19, 1'b1, d, t, ok);
        check(d, 18'h3FFFF);
        $display("second reset done");
        wrap_up();
    end
endmodule : adc_serial_readout_standby_test
`default_nettype wire
